// file: src/mim_top.sv
// Low-half interrupt enable mask with event capture and interrupt output
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// (R01) Selected waveform page full raises interrupt
// (R02) Capture stop after trigger raises interrupt
// (R03) New waveform samples raise interrupt
// (R04) Sample rate follows source selection
// (R05) Pulse falling edge raises interrupt, four enables
// (R06) Pulse sign change raises interrupt, four enables
// (R07) Per-phase reactive sign change interrupts
// (R08) Per-phase active sign change interrupts
// (R09) Energy update after programmed period fires
// (R10) Record pulse sign at pulse fall
// (R11) Enables read/write, reset zero, gate output
// (R12) Flags record regardless of enables
module mim_top
  import mim_pkg::*;
#(
  parameter int PERIOD_W = 16
)(
  // Clock, reset and clock enable
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Event sources
  input wire logic [15:0] i_page_done,
  input wire logic i_capture_stopped,
  input wire logic [3:0] i_sample_strobe,
  input wire logic [3:0] i_pulse_pin,
  input wire logic [3:0] i_pulse_sign,
  input wire logic [2:0] i_active_sign,
  input wire logic [2:0] i_reactive_sign,
  input wire logic i_energy_sample_tick,
  input wire logic i_energy_cycle_tick,
  input wire logic [PERIOD_W-1:0] i_energy_period_count,
  // Interrupt and sign record
  output logic o_irq,
  output logic [3:0] o_pulse_sign_rec
);

  // Bundled request and events
  mim_req_t req;
  mim_evt_t evt;
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
  assign evt = '{page_done: i_page_done, capture_stopped: i_capture_stopped,
                 sample_strobe: i_sample_strobe, pulse_pin: i_pulse_pin,
                 pulse_sign: i_pulse_sign, active_sign: i_active_sign,
                 reactive_sign: i_reactive_sign,
                 energy_sample_tick: i_energy_sample_tick,
                 energy_cycle_tick: i_energy_cycle_tick};

  // Address match helper used by both read and write decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Software state
  logic [MIM_NBITS-1:0] irq_enable_mask_a; // Enable bits
  logic [31:0] src_cfg; // Source configuration word
  logic [3:0] pulse_prev; // Last pulse pin levels
  logic [3:0] pulse_sign_rec; // Sign of last pulse per output
  logic [3:0] pulse_sign_seen; // A first pulse has been recorded
  logic [2:0] active_prev; // Last active sign
  logic [2:0] reactive_prev; // Last reactive sign
  logic [15:0] page_prev; // Last page done levels
  logic capture_prev; // Last capture stopped level
  logic [PERIOD_W-1:0] egy_cnt; // Energy period counter
  mim_rd_t rd_state; // Read pipeline state

  // Decoded strobes
  wire wr_mask = req.wr && hit(req.addr, MIM_OFS_MASK);
  wire wr_cfg = req.wr && hit(req.addr, MIM_OFS_SRCCFG);
  wire rd_status = req.rd && hit(req.addr, MIM_OFS_STATUS);

  // Configuration fields
  wire [1:0] sample_source_select = src_cfg[MIM_F_SRC_LO +: MIM_F_SRC_W];
  wire energy_period_unit_select = src_cfg[MIM_F_UNIT];
  wire [15:0] page_irq_select = src_cfg[MIM_F_PAGE_LO +: MIM_F_PAGE_W];

  // Event detection
  wire [15:0] page_rise = evt.page_done & ~page_prev;
  wire page_evt = |(page_rise & page_irq_select); // R01
  wire capture_evt = evt.capture_stopped & ~capture_prev; // R02
  wire sample_evt = evt.sample_strobe[sample_source_select]; // R03 R04
  wire [3:0] pulse_fall = pulse_prev & ~evt.pulse_pin; // R05
  wire [3:0] psign_evt = pulse_fall & pulse_sign_seen & (evt.pulse_sign ^ pulse_sign_rec); // R06
  wire [2:0] reactive_evt = evt.reactive_sign ^ reactive_prev; // R07
  wire [2:0] active_evt = evt.active_sign ^ active_prev; // R08
  wire egy_tick = energy_period_unit_select ? evt.energy_cycle_tick : evt.energy_sample_tick;
  wire egy_evt = egy_tick && (egy_cnt >= i_energy_period_count); // R09

  // Assemble event vector in mask bit order
  logic [MIM_NBITS-1:0] evt_vec;
  assign evt_vec = {page_evt, capture_evt, sample_evt, pulse_fall, psign_evt,
                    reactive_evt, active_evt, egy_evt};

  // Sticky status flags, recorded regardless of enables
  logic [MIM_NBITS-1:0] status;
  mim_sticky #(.N(MIM_NBITS)) u_flags (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_set(evt_vec), // R12
    .i_clr(rd_status),
    .o_flags(status)
  );

  // Interrupt is enabled flags combined
  wire next_irq = |(status & irq_enable_mask_a); // R11

  // Register writes
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      irq_enable_mask_a <= MIM_RST_MASK[MIM_NBITS-1:0]; // R11
      src_cfg <= MIM_RST_ZERO;
    end
    else if (i_ce)
    begin
      if (wr_mask)
        irq_enable_mask_a <= req.wdata[MIM_NBITS-1:0]; // R11
      if (wr_cfg)
        src_cfg <= req.wdata;
    end
  end

  // Edge history registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pulse_prev <= '0;
      active_prev <= '0;
      reactive_prev <= '0;
      page_prev <= '0;
      capture_prev <= 1'b0;
    end
    else if (i_ce)
    begin
      pulse_prev <= evt.pulse_pin;
      active_prev <= evt.active_sign;
      reactive_prev <= evt.reactive_sign;
      page_prev <= evt.page_done;
      capture_prev <= evt.capture_stopped;
    end
  end

  // Pulse sign record, captured on each falling pulse pin
  genvar g;
  generate
    for (g = 0; g < MIM_NPULSE; g++)
    begin : g_sign
      always_ff @(posedge i_mclk)
      begin
        if (i_srst)
        begin
          pulse_sign_rec[g] <= 1'b0;
          pulse_sign_seen[g] <= 1'b0;
        end
        else if (i_ce && pulse_fall[g])
        begin
          pulse_sign_rec[g] <= evt.pulse_sign[g]; // R10
          pulse_sign_seen[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Energy period counter: counts selected ticks, restarts on update
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      egy_cnt <= '0;
    else if (i_ce && egy_tick)
      egy_cnt <= egy_evt ? '0 : egy_cnt + 1'b1; // R09
  end

  // Read data mux
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (req.addr)
      MIM_OFS_MASK: next_rdata = {{(32-MIM_NBITS){1'b0}}, irq_enable_mask_a};
      MIM_OFS_STATUS: next_rdata = {{(32-MIM_NBITS){1'b0}}, status};
      MIM_OFS_SIGN: next_rdata = {28'h000_0000, pulse_sign_rec};
      MIM_OFS_SRCCFG: next_rdata = src_cfg;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Output registers; read data stand one cycle after the read strobe
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_rdata <= 32'h0000_0000;
      o_irq <= 1'b0;
      o_pulse_sign_rec <= 4'h0;
      rd_state <= MIM_RD_IDLE;
    end
    else if (i_ce)
    begin
      o_rdata <= req.rd ? next_rdata : 32'h0000_0000;
      o_irq <= next_irq;
      o_pulse_sign_rec <= pulse_sign_rec;
      rd_state <= req.rd ? MIM_RD_DATA : MIM_RD_IDLE;
    end
  end

  // Assertions
  mask_reset_a: assert property (@(posedge i_mclk) $rose(i_srst) |=> irq_enable_mask_a == '0) // R11
    else $error("mask not cleared by reset");
  irq_gate_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> o_irq == |($past(status) & $past(irq_enable_mask_a))) // R11
    else $error("irq does not follow enabled flags");
  flag_record_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && |evt_vec) |=> ((status & $past(evt_vec)) == $past(evt_vec))) // R12
    else $error("event not recorded");
  page_full_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && page_evt) |=> status[MIM_B_PAGE_FULL]) // R01
    else $error("page flag missing");
  capture_stop_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && capture_evt) |=> status[MIM_B_CAPTURE_STOP]) // R02
    else $error("capture stop flag missing");
  sample_ready_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_sample_strobe[sample_source_select]) |=> status[MIM_B_SAMPLE_RDY]) // R03
    else $error("sample ready flag missing");
  pulse_fall_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && pulse_prev[0] && !i_pulse_pin[0]) |=> status[MIM_B_PULSE_LO]) // R05
    else $error("pulse flag missing");
  sign_record_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && pulse_fall[0]) |=> pulse_sign_rec[0] == $past(i_pulse_sign[0])) // R10
    else $error("pulse sign not recorded");
  active_sign_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && i_active_sign[0] != active_prev[0]) |=> status[MIM_B_ACTIVE_LO]) // R08
    else $error("active sign flag missing");
  read_timing_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !i_rd) |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  // Read data may only be nonzero in the slot right after a read strobe
  read_slot_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (o_rdata != 32'h0000_0000) |-> (rd_state == MIM_RD_DATA)) // R11
    else $error("read data outside read slot");

  // A low clock enable freezes the enables and the interrupt level
  ce_freeze_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !i_ce |=> ($stable(irq_enable_mask_a) && $stable(o_irq))) // R11
    else $error("state moved while clock enable low");

  // A pulse sign change sets its own flag
  psign_flag_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && psign_evt[0]) |=> status[MIM_B_PSIGN_LO]) // R06
    else $error("pulse sign change flag missing");

  // Phase B reactive sign change sets the phase B flag
  reactive_sign_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && reactive_evt[1]) |=> status[MIM_B_REACTIVE_LO + 1]) // R07
    else $error("reactive sign flag missing");

  // Energy update sets its flag and restarts the period counter
  energy_ready_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && egy_evt) |=> (status[MIM_B_ENERGY_RDY] && egy_cnt == '0)) // R09
    else $error("energy update not flagged");

  // A status read with no new event leaves every flag clear
  status_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && rd_status && !(|evt_vec)) |=> (status == '0)) // R12
    else $error("status not cleared by read");

  // The sign output mirrors the internal record one cycle later
  sign_out_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce |=> (o_pulse_sign_rec == $past(pulse_sign_rec))) // R10
    else $error("sign output does not follow record");

endmodule : mim_top

// file: src/mim_pkg.sv
// Package of constants, types and register map for the interrupt enable block
package mim_pkg;

  // Register word width and bus address width
  localparam int MIM_DW = 32;
  localparam int MIM_AW = 4;

  // Register offsets (word indices on the plain register port)
  localparam logic [3:0] MIM_OFS_MASK = 4'h0;
  localparam logic [3:0] MIM_OFS_STATUS = 4'h1;
  localparam logic [3:0] MIM_OFS_SIGN = 4'h2;
  localparam logic [3:0] MIM_OFS_SRCCFG = 4'h3;

  // Bit positions of the low half of the first mask register
  localparam int MIM_B_ENERGY_RDY = 0;
  localparam int MIM_B_ACTIVE_LO = 1;
  localparam int MIM_B_REACTIVE_LO = 4;
  localparam int MIM_B_PSIGN_LO = 7;
  localparam int MIM_B_PULSE_LO = 11;
  localparam int MIM_B_SAMPLE_RDY = 15;
  localparam int MIM_B_CAPTURE_STOP = 16;
  localparam int MIM_B_PAGE_FULL = 17;
  localparam int MIM_NBITS = 18;

  // Counts of per-phase and per-pulse sources
  localparam int MIM_NPHASE = 3;
  localparam int MIM_NPULSE = 4;

  // Reset values
  localparam logic [31:0] MIM_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] MIM_RST_ZERO = 32'h0000_0000;

  // Field layout of the source configuration register
  localparam int MIM_F_SRC_LO = 0;
  localparam int MIM_F_SRC_W = 2;
  localparam int MIM_F_UNIT = 4;
  localparam int MIM_F_PAGE_LO = 16;
  localparam int MIM_F_PAGE_W = 16;

  // Register port request as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } mim_req_t;

  // Raw event inputs from the metering core
  typedef struct packed {
    logic [15:0] page_done;
    logic capture_stopped;
    logic [3:0] sample_strobe;
    logic [3:0] pulse_pin;
    logic [3:0] pulse_sign;
    logic [2:0] active_sign;
    logic [2:0] reactive_sign;
    logic energy_sample_tick;
    logic energy_cycle_tick;
  } mim_evt_t;

  // Read pipeline slot states
  typedef enum logic [1:0] {
    MIM_RD_IDLE = 2'b00,
    MIM_RD_DATA = 2'b01
  } mim_rd_t;

endpackage : mim_pkg

// file: src/mim_sticky.sv
// Sticky event flag bank with set-over-clear and clear on status read
`timescale 1ns/10ps
module mim_sticky
  import mim_pkg::*;
#(
  parameter int N = 18
)(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Events and clear
  input wire logic [N-1:0] i_set,
  input wire logic i_clr,
  // Flag state
  output logic [N-1:0] o_flags
);

  // Flags update: a new event wins over a read clear in the same cycle
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      o_flags <= '0;
    else if (i_ce)
      o_flags <= (i_clr ? '0 : o_flags) | i_set;
  end

endmodule : mim_sticky

// file: sim/tb_top.sv
// Self-checking bench for the low-half interrupt enable mask block
`timescale 1ns/10ps
module tb_top;
  import mim_pkg::*;
  // Design ports
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  mim_evt_t evt = '0; // Event sources as one bundle
  logic [15:0] i_energy_period_count = 16'h0002;
  logic o_irq;
  logic [3:0] o_pulse_sign_rec;
  // Bench state
  logic [31:0] mask = 32'h0000_0000; // Copy of the mask last written
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic rd_pend = 1'b0; // A read was taken on the last edge
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int rs;
  int per;

  // Free-running clock
  always #5 i_mclk = ~i_mclk;

  mim_top dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_page_done(evt.page_done),
    .i_capture_stopped(evt.capture_stopped), .i_sample_strobe(evt.sample_strobe),
    .i_pulse_pin(evt.pulse_pin), .i_pulse_sign(evt.pulse_sign), .i_active_sign(evt.active_sign),
    .i_reactive_sign(evt.reactive_sign), .i_energy_sample_tick(evt.energy_sample_tick),
    .i_energy_cycle_tick(evt.energy_cycle_tick), .i_energy_period_count(i_energy_period_count),
    .o_irq(o_irq), .o_pulse_sign_rec(o_pulse_sign_rec));

  // Compare a 32-bit result
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp32

  // Compare the interrupt level at a settled point
  task automatic chk_irq(input logic exp);
    @(negedge i_mclk);
    total_checks++;
    if (o_irq !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, o_irq, exp);
    end
  endtask : chk_irq

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // One-cycle register read, expectation noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(exp);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask : rd

  // Monitor takes read data in the cycle after the strobe
  always @(posedge i_mclk)
  begin
    if (rd_pend)
      cmp32(o_rdata, exp_q.pop_front());
    rd_pend <= i_rd;
  end

  // Enable either only the coming event or everything else
  task automatic arm(input logic [31:0] bits);
    mask = ($urandom % 2) ? bits : (~bits & 32'h0003_ffff);
    wr(MIM_OFS_MASK, mask);
  endtask : arm

  // Interrupt follows status and mask, status clears on read
  task automatic expect_evt(input logic [31:0] bits);
    tick(4);
    chk_irq(|(bits & mask));
    rd(MIM_OFS_STATUS, bits);
    rd(MIM_OFS_STATUS, 32'h0000_0000);
    tick(2);
    chk_irq(1'b0);
  endtask : expect_evt

  // Energy pulse with a given sign; a changed sign also flags
  task automatic pulse(input int k, input logic s, input logic chg);
    logic [31:0] bits;
    bits = (32'h1 << (MIM_B_PULSE_LO + k)) | (32'(chg) << (MIM_B_PSIGN_LO + k));
    arm(bits);
    evt.pulse_sign[k] <= s;
    evt.pulse_pin[k] <= 1'b1;
    tick(2);
    evt.pulse_pin[k] <= 1'b0;
    expect_evt(bits);
    rd(MIM_OFS_SIGN, 32'(s) << k);
    cmp32({28'h0, o_pulse_sign_rec}, 32'(s) << k);
  endtask : pulse

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Hang guard
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    rs = $urandom(32'heb08);
    tick(12);
    i_srst <= 1'b0;
    rd(MIM_OFS_MASK, MIM_RST_MASK);
    rd(MIM_OFS_STATUS, MIM_RST_ZERO);
    rd(MIM_OFS_SIGN, MIM_RST_ZERO);
    rd(MIM_OFS_SRCCFG, MIM_RST_ZERO);
    rd(4'h9, 32'h0000_0000);
    chk_irq(1'b0);
    $display("reset test done");
    // Mask read-back, status not writable
    repeat (4)
    begin
      rs = $urandom;
      wr(MIM_OFS_MASK, rs);
      rd(MIM_OFS_MASK, rs & 32'h0003_ffff);
    end
    wr(MIM_OFS_STATUS, 32'hffff_ffff);
    rd(MIM_OFS_STATUS, 32'h0000_0000);
    $display("mask test done");
    // Capture stop, recorded whatever the mask
    repeat (3)
    begin
      arm(32'h0001_0000);
      evt.capture_stopped <= 1'b1;
      expect_evt(32'h0001_0000);
      evt.capture_stopped <= 1'b0;
    end
    // Per-phase power sign changes
    for (int ph = 0; ph < 3; ph++)
    begin
      arm(32'h1 << (MIM_B_ACTIVE_LO + ph));
      evt.active_sign[ph] <= ~evt.active_sign[ph];
      expect_evt(32'h1 << (MIM_B_ACTIVE_LO + ph));
      arm(32'h1 << (MIM_B_REACTIVE_LO + ph));
      evt.reactive_sign[ph] <= ~evt.reactive_sign[ph];
      expect_evt(32'h1 << (MIM_B_REACTIVE_LO + ph));
    end
    $display("sign test done");
    // Pulses: same sign, then changed twice
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 3; i++)
        pulse(k, i == 1, i > 0);
    $display("pulse test done");
    // A write while the clock enable is low must not land
    i_ce <= 1'b0;
    wr(MIM_OFS_MASK, 32'hffff_ffff);
    i_ce <= 1'b1;
    rd(MIM_OFS_MASK, mask & 32'h0003_ffff);
    $display("enable test done");
    // Sample ready only from the selected source
    for (int src = 0; src < 4; src++)
    begin
      wr(MIM_OFS_SRCCFG, 32'(src));
      for (int j = 0; j < 4; j++)
      begin
        arm(32'h0000_8000);
        evt.sample_strobe[j] <= 1'b1;
        tick(1);
        evt.sample_strobe[j] <= 1'b0;
        expect_evt((j == src) ? 32'h0000_8000 : 32'h0000_0000);
      end
    end
    // Page full only for a selected page
    rs = $urandom % 16;
    wr(MIM_OFS_SRCCFG, 32'h1 << (16 + rs));
    arm(32'h0002_0000);
    evt.page_done[(rs + 1) % 16] <= 1'b1;
    expect_evt(32'h0000_0000);
    evt.page_done[rs] <= 1'b1;
    expect_evt(32'h0002_0000);
    evt.page_done <= 16'h0000;
    $display("buffer test done");
    // Energy ready after period plus one selected ticks
    for (int u = 0; u < 2; u++)
    begin
      per = 1 + $urandom % 4;
      i_energy_period_count <= 16'(per);
      wr(MIM_OFS_SRCCFG, 32'(u) << MIM_F_UNIT);
      arm(32'h0000_0001);
      repeat (per)
      begin
        evt.energy_sample_tick <= 1'b1;
        evt.energy_cycle_tick <= 1'b1;
        tick(1);
        evt.energy_sample_tick <= 1'b0;
        evt.energy_cycle_tick <= 1'b0;
        tick(1);
      end
      expect_evt(32'h0000_0000);
      evt.energy_sample_tick <= (u == 0);
      evt.energy_cycle_tick <= (u == 1);
      tick(1);
      evt.energy_sample_tick <= 1'b0;
      evt.energy_cycle_tick <= 1'b0;
      expect_evt(32'h0000_0001);
    end
    $display("energy test done");
    tick(4);
    end_of_test();
  end
endmodule : tb_top
